/* inc/vcc_cfg.svh */
// Register map, field positions, reset values and counts for the comparator control block.
// Assumes an APB slave with 32-bit data, one register per aligned word.
`ifndef VCC_CFG_SVH
`define VCC_CFG_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define VCC_CTRL0_IDX     8'h9A
`define VCC_MODE0_IDX     8'h9B
`define VCC_CTRL1_IDX     8'h9D
`define VCC_MODE1_IDX     8'h9E
`define VCC_MUX0_IDX      8'h9F
`define VCC_MUX1_IDX      8'hA0
`define VCC_ADDR_W        12
`define VCC_BYTE_ADDR(i)  ({2'h0, (i), 2'h0})

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define VCC_CTL_ON        7
`define VCC_CTL_RESULT    6
`define VCC_CTL_RISE      5
`define VCC_CTL_FALL      4
`define VCC_CTL_PHYS_HI   3
`define VCC_CTL_PHYS_LO   2
`define VCC_CTL_NHYS_HI   1
`define VCC_CTL_NHYS_LO   0

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define VCC_MD_RISE_IE    5
`define VCC_MD_FALL_IE    4
`define VCC_MD_SPD_HI     1
`define VCC_MD_SPD_LO     0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VCC_CTRL_RST      8'h00
`define VCC_SPEED_RST     2'h2
`define VCC_MUX_RST       8'h77

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define VCC_NUM_CMP       2

`endif

/* inc/vcc_pkg.sv */
// Types shared by the comparator control block.
// Assumes vcc_cfg.svh supplies the numeric constants.
package vcc_pkg;

    // Settings that one comparator presents to its analog core
    typedef struct packed {
        logic       power_on;
        logic [1:0] pos_hyst_sel;
        logic [1:0] neg_hyst_sel;
        logic [1:0] speed_power_sel;
        logic [3:0] plus_input_sel;
        logic [3:0] minus_input_sel;
    } vcc_analog_cfg_type;

    // Outputs one comparator offers to the crossbar
    typedef struct packed {
        logic latched_cmp_out;
        logic raw_cmp_out;
    } vcc_pin_out_type;

    // APB access state
    typedef enum logic [1:0] {
        VCC_IDLE   = 2'b01,
        VCC_ACCESS = 2'b10
    } vcc_apb_state_type;

endpackage

/* design/vcc_top.sv */
// Digital control and status for two on-chip voltage comparators, reached over APB.
// Assumes the analog cores drive cmp_analog asynchronously and take their settings from analog_cfg.
//
// Notes on behaviour
// - Two identical comparators; first also feeds reset.
// - Each has a clocked and an unclocked output.
// - Unclocked output follows comparison without clock.
// - Disabled comparator: pin output low, power off.
// - Separate plus and minus input select fields.
// - Falling edge sets falling flag.
// - Rising edge sets rising flag.
// - Edge flags stay set until software writes zero.
// - Result bit reads current comparison.
// - Control bit 7 enables, resets zero.
// - Control bits 3:2 pick positive hysteresis.
// - Control bits 1:0 pick negative hysteresis.
// - Mode bit 5 enables rising interrupt.
// - Mode bit 4 enables falling interrupt.
// - Mode bits 1:0 pick speed, reset 10.
// - Mode bits 7:6 and 3:2 read zero.
// - Interrupts on both rising and falling edges.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "vcc_cfg.svh"

module vcc_top #(
    parameter int NUM_CMP = `VCC_NUM_CMP
)(
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [`VCC_ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                       pwdata,
    input  wire logic [3:0]                        pstrb,
    output logic                                   pready,
    output logic [31:0]                            prdata,
    output logic                                   pslverr,
    input  wire logic [NUM_CMP-1:0]                cmp_analog,
    output vcc_pkg::vcc_analog_cfg_type [NUM_CMP-1:0] analog_cfg,
    output vcc_pkg::vcc_pin_out_type [NUM_CMP-1:0] pin_out,
    output logic [NUM_CMP-1:0]                     cmp_irq,
    output logic                                   reset_src_out
);

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    vcc_pkg::vcc_apb_state_type state_q;
    vcc_pkg::vcc_apb_state_type state_d;
    logic                       setup_w;
    logic                       ack_w;
    logic                       wr_hit_w;
    logic [31:0]                rdata_w;
    logic                       map_hit_w;
    logic                       low_lane_w;

    // Access phase costs one wait state so read data comes from a flop
    assign setup_w  = psel && !penable && (state_q == vcc_pkg::VCC_IDLE);
    assign ack_w    = psel && penable && (state_q == vcc_pkg::VCC_ACCESS);
    assign wr_hit_w = psel && penable && pwrite && pready;
    assign low_lane_w = pstrb[0];

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            vcc_pkg::VCC_IDLE:
            begin
                if (setup_w)
                    state_d = vcc_pkg::VCC_ACCESS;
            end
            vcc_pkg::VCC_ACCESS:
            begin
                if (psel && penable)
                    state_d = vcc_pkg::VCC_IDLE;
            end
            default:
                state_d = vcc_pkg::VCC_IDLE;
        endcase
    end

    // Ready and read data are registered, presented in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= vcc_pkg::VCC_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pready  <= ack_w;
            prdata  <= (ack_w && !pwrite) ? rdata_w : 32'h0000_0000;
            pslverr <= ack_w && !map_hit_w;
        end
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic [NUM_CMP-1:0] sel_ctrl_w;
    logic [NUM_CMP-1:0] sel_mode_w;
    logic [NUM_CMP-1:0] sel_mux_w;
    logic [NUM_CMP-1:0] wr_ctrl_w;
    logic [NUM_CMP-1:0] wr_mode_w;
    logic [NUM_CMP-1:0] wr_mux_w;
    logic [7:0]         ctrl_rd_w [NUM_CMP];
    logic [7:0]         mode_rd_w [NUM_CMP];
    logic [7:0]         mux_rd_w  [NUM_CMP];
    logic               do_write_w;

    // Write takes effect only at the edge where pready is sampled high
    assign do_write_w = wr_hit_w && low_lane_w;

    // ----------------------------------------------------------------
    // Per-comparator logic
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++)
        begin : g_cmp
            localparam logic [7:0] CTRL_IDX = (g == 0) ? `VCC_CTRL0_IDX : `VCC_CTRL1_IDX;
            localparam logic [7:0] MODE_IDX = (g == 0) ? `VCC_MODE0_IDX : `VCC_MODE1_IDX;
            localparam logic [7:0] MUX_IDX  = (g == 0) ? `VCC_MUX0_IDX  : `VCC_MUX1_IDX;

            logic       cmp_on_q;
            logic       rise_seen_flag_q;
            logic       fall_seen_flag_q;
            logic [1:0] pos_hyst_sel_q;
            logic [1:0] neg_hyst_sel_q;
            logic       rise_irq_on_q;
            logic       fall_irq_on_q;
            logic [1:0] speed_power_sel_q;
            logic [3:0] plus_input_sel_q;
            logic [3:0] minus_input_sel_q;
            logic       sync1_q;
            logic       sync2_q;
            logic       prev_q;
            logic       latched_q;
            logic       irq_q;
            logic       rise_ev_w;
            logic       fall_ev_w;
            logic       gated_w;

            assign sel_ctrl_w[g] = (paddr == `VCC_BYTE_ADDR(CTRL_IDX));
            assign sel_mode_w[g] = (paddr == `VCC_BYTE_ADDR(MODE_IDX));
            assign sel_mux_w[g]  = (paddr == `VCC_BYTE_ADDR(MUX_IDX));
            assign wr_ctrl_w[g]  = do_write_w && sel_ctrl_w[g];
            assign wr_mode_w[g]  = do_write_w && sel_mode_w[g];
            assign wr_mux_w[g]   = do_write_w && sel_mux_w[g];

            // Disabled core drives low; edges compare synchronised samples only
            assign gated_w   = cmp_on_q && sync2_q;
            assign rise_ev_w = gated_w && !prev_q;
            assign fall_ev_w = !gated_w && prev_q;

            assign ctrl_rd_w[g] = {cmp_on_q, latched_q, rise_seen_flag_q, fall_seen_flag_q,
                                   pos_hyst_sel_q, neg_hyst_sel_q};
            assign mode_rd_w[g] = {2'h0, rise_irq_on_q, fall_irq_on_q, 2'h0, speed_power_sel_q};
            assign mux_rd_w[g]  = {minus_input_sel_q, plus_input_sel_q};

            // Settings written by software
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cmp_on_q          <= 1'b0;
                    pos_hyst_sel_q    <= 2'h0;
                    neg_hyst_sel_q    <= 2'h0;
                    rise_irq_on_q     <= 1'b0;
                    fall_irq_on_q     <= 1'b0;
                    speed_power_sel_q <= `VCC_SPEED_RST;
                    plus_input_sel_q  <= 4'(`VCC_MUX_RST);
                    minus_input_sel_q <= 4'(`VCC_MUX_RST >> 4);
                end
                else
                begin
                    if (wr_ctrl_w[g])
                    begin
                        cmp_on_q       <= pwdata[`VCC_CTL_ON];
                        pos_hyst_sel_q <= pwdata[`VCC_CTL_PHYS_HI:`VCC_CTL_PHYS_LO];
                        neg_hyst_sel_q <= pwdata[`VCC_CTL_NHYS_HI:`VCC_CTL_NHYS_LO];
                    end
                    if (wr_mode_w[g])
                    begin
                        rise_irq_on_q     <= pwdata[`VCC_MD_RISE_IE];
                        fall_irq_on_q     <= pwdata[`VCC_MD_FALL_IE];
                        speed_power_sel_q <= pwdata[`VCC_MD_SPD_HI:`VCC_MD_SPD_LO];
                    end
                    if (wr_mux_w[g])
                    begin
                        plus_input_sel_q  <= pwdata[3:0];
                        minus_input_sel_q <= pwdata[7:4];
                    end
                end
            end

            // Sticky flags: a same-cycle edge beats a software clear
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    rise_seen_flag_q <= 1'b0;
                    fall_seen_flag_q <= 1'b0;
                end
                else
                begin
                    if (rise_ev_w)
                        rise_seen_flag_q <= 1'b1;
                    else if (wr_ctrl_w[g])
                        rise_seen_flag_q <= rise_seen_flag_q & pwdata[`VCC_CTL_RISE];
                    if (fall_ev_w)
                        fall_seen_flag_q <= 1'b1;
                    else if (wr_ctrl_w[g])
                        fall_seen_flag_q <= fall_seen_flag_q & pwdata[`VCC_CTL_FALL];
                end
            end

            // Two-flop synchroniser; the first stage feeds only the second
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_q   <= 1'b0;
                    sync2_q   <= 1'b0;
                    prev_q    <= 1'b0;
                    latched_q <= 1'b0;
                    irq_q     <= 1'b0;
                end
                else
                begin
                    sync1_q   <= cmp_analog[g];
                    sync2_q   <= sync1_q;
                    prev_q    <= gated_w;
                    latched_q <= gated_w;
                    irq_q     <= (rise_seen_flag_q && rise_irq_on_q) ||
                                 (fall_seen_flag_q && fall_irq_on_q);
                end
            end

            // Raw path bypasses every flop so it keeps following the core with the clock stopped;
            // the enable gate alone holds it low while the core is off
            assign pin_out[g].raw_cmp_out     = cmp_on_q & cmp_analog[g];
            assign pin_out[g].latched_cmp_out = latched_q;
            assign cmp_irq[g]                 = irq_q;
            assign analog_cfg[g].power_on        = cmp_on_q;
            assign analog_cfg[g].pos_hyst_sel    = pos_hyst_sel_q;
            assign analog_cfg[g].neg_hyst_sel    = neg_hyst_sel_q;
            assign analog_cfg[g].speed_power_sel = speed_power_sel_q;
            assign analog_cfg[g].plus_input_sel  = plus_input_sel_q;
            assign analog_cfg[g].minus_input_sel = minus_input_sel_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read mux and reset-source path
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_w   = 32'h0000_0000;
        map_hit_w = 1'b0;
        for (int i = 0; i < NUM_CMP; i++)
        begin
            if (sel_ctrl_w[i])
            begin
                rdata_w   = {24'h00_0000, ctrl_rd_w[i]};
                map_hit_w = 1'b1;
            end
            if (sel_mode_w[i])
            begin
                rdata_w   = {24'h00_0000, mode_rd_w[i]};
                map_hit_w = 1'b1;
            end
            if (sel_mux_w[i])
            begin
                rdata_w   = {24'h00_0000, mux_rd_w[i]};
                map_hit_w = 1'b1;
            end
        end
    end

    // Only the first comparator may act as a reset source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_src_out <= 1'b0;
        else
            reset_src_out <= !g_cmp[0].latched_q && g_cmp[0].cmp_on_q;
    end

endmodule // vcc_top

/* tb/vcc_analog_model.sv */
// Behavioural model of the two analog comparator cores.
// Assumes the bench sets each comparison level; a core without supply drives low.
`timescale 1ns/1ps
module vcc_analog_model (
    input  wire vcc_pkg::vcc_analog_cfg_type [1:0] cfg,
    input  wire logic [1:0]                        level,
    output logic [1:0]                             cmp_analog
);
    // No clock here: the result follows the level at once, powered cores only
    assign cmp_analog[0] = cfg[0].power_on & level[0];
    assign cmp_analog[1] = cfg[1].power_on & level[1];
endmodule // vcc_analog_model

/* tb/vcc_sva.sv */
// Port assertions for the APB side and comparator 0 of the control block.
// Assumes a bind onto vcc_top; one clock pclk, async active-low presetn.
`timescale 1ns/1ps
module vcc_sva #(
    parameter int NUM_CMP = 2
)(
    input wire logic                                  pclk,
    input wire logic                                  presetn,
    input wire logic                                  psel,
    input wire logic                                  penable,
    input wire logic                                  pwrite,
    input wire logic [11:0]                           paddr,
    input wire logic [31:0]                           pwdata,
    input wire logic [3:0]                            pstrb,
    input wire logic                                  pready,
    input wire logic [31:0]                           prdata,
    input wire logic                                  pslverr,
    input wire logic [NUM_CMP-1:0]                    cmp_analog,
    input wire vcc_pkg::vcc_analog_cfg_type [NUM_CMP-1:0] analog_cfg,
    input wire vcc_pkg::vcc_pin_out_type [NUM_CMP-1:0]    pin_out,
    input wire logic [NUM_CMP-1:0]                    cmp_irq,
    input wire logic                                  reset_src_out
);
    // Word index 0x9C is a hole between the two comparators
    wire logic [9:0] idx = paddr[11:2];
    wire logic       map = paddr[1:0] == 2'h0 && idx >= 10'h09A && idx <= 10'h0A0 && idx != 10'h09C;
    wire logic       wr0 = psel & penable & pready & pwrite & pstrb[0];
    wire logic       rd0 = pready & ~pwrite;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready not on 2nd access");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    chk_slverr_map: assert property (pready |-> pslverr == !map) else $error("pslverr wrong for address");
    chk_rdata_idle: assert property (!rd0 |-> prdata == 32'h0) else $error("prdata not zero outside read");
    chk_rdata_upper: assert property (rd0 |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_mode_unused: assert property (rd0 && idx == 10'h09B |-> prdata[7:6] == 2'h0 && prdata[3:2] == 2'h0)
        else $error("unused mode bits set");
    chk_ctrl_write: assert property (wr0 && idx == 10'h09A |=> analog_cfg[0].power_on == $past(pwdata[7])
        && analog_cfg[0].pos_hyst_sel == $past(pwdata[3:2]) && analog_cfg[0].neg_hyst_sel == $past(pwdata[1:0]))
        else $error("control write not applied");
    chk_speed_write: assert property (wr0 && idx == 10'h09B |=> analog_cfg[0].speed_power_sel == $past(pwdata[1:0]))
        else $error("speed write not applied");
    chk_raw_gated: assert property (pin_out[0].raw_cmp_out == (analog_cfg[0].power_on & cmp_analog[0]))
        else $error("raw output not gated by enable");
    chk_latch_sync: assert property (pin_out[0].latched_cmp_out ==
        ($past(cmp_analog[0], 3) && $past(analog_cfg[0].power_on)))
        else $error("latched output timing wrong");
    chk_irq_rise: assert property ($rose(cmp_irq[0]) |-> $past(wr0, 2)
        || $past(pin_out[0].latched_cmp_out) != $past(pin_out[0].latched_cmp_out, 2)) else $error("irq rose alone");
    chk_irq_fall: assert property ($fell(cmp_irq[0]) |-> $past(wr0, 2)) else $error("irq fell alone");
    chk_reset_src: assert property (reset_src_out == $past(analog_cfg[0].power_on & !pin_out[0].latched_cmp_out))
        else $error("reset source wrong");

    cover property (wr0 && idx == 10'h09A);
    cover property ($rose(cmp_irq[0]));
    cover property (pready && pslverr);
    cover property ($fell(pin_out[0].latched_cmp_out));
endmodule // vcc_sva

/* tb/tb_top.sv */
// Self-checking bench: APB master tasks and hand-written scenarios.
// Assumes vcc_top, vcc_analog_model and vcc_sva are compiled first.
`timescale 1ns/1ps
`include "vcc_cfg.svh"
module tb_top;
    logic                              pclk, presetn, psel, penable, pwrite, pslverr, pready, err;
    logic                              reset_src_out;
    logic [11:0]                       paddr;
    logic [31:0]                       pwdata, prdata, rd;
    logic [3:0]                        pstrb;
    logic [1:0]                        cmp_analog, cmp_irq, level;
    vcc_pkg::vcc_analog_cfg_type [1:0] analog_cfg;
    vcc_pkg::vcc_pin_out_type [1:0]    pin_out;
    int                                fail_count = 0;
    int                                n_tests = 0;

    vcc_top #(.NUM_CMP(2)) vcc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cmp_analog(cmp_analog), .analog_cfg(analog_cfg), .pin_out(pin_out),
        .cmp_irq(cmp_irq), .reset_src_out(reset_src_out));
    vcc_analog_model vcc_analog_model_inst (.cfg(analog_cfg), .level(level), .cmp_analog(cmp_analog));

    // 50 MHz system clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask

    // One APB transfer; the trailing 1 ns lets the write land before checks
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (n >= 16)
        begin
            fail_count++;
            stop_test();
        end
    endtask

    task automatic wt(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, {24'h0, exp});
        chk("read err", {31'h0, err}, 32'h0);
    endtask

    function automatic logic [11:0] ra(input int i, input bit md);
        logic [7:0] x;
        x = md ? (i ? `VCC_MODE1_IDX : `VCC_MODE0_IDX) : (i ? `VCC_CTRL1_IDX : `VCC_CTRL0_IDX);
        return `VCC_BYTE_ADDR(x);
    endfunction

    // Level changes land on an edge; six edges cover sync, flag and irq
    task automatic lv(input int i, input logic b);
        @(posedge pclk);
        level[i] <= b;
        repeat (6) @(posedge pclk);
        #1;
    endtask

    task automatic irqc(input int i, input logic exp);
        @(posedge pclk);
        #1;
        chk("irq", {31'h0, cmp_irq[i]}, {31'h0, exp});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 2; i++)
        begin
            rdc("ctrl reset", ra(i, 0), 8'h00);
            rdc("mode reset", ra(i, 1), 8'h02);
            chk("speed reset", {30'h0, analog_cfg[i].speed_power_sel}, 32'h2);
        end
        $display("t_reset done");
    endtask

    task automatic t_fields;
        logic [1:0]  v;
        logic [11:0] ma;
        for (int k = 0; k < 4; k++)
        begin
            v = k[1:0];
            wt(ra(0, 0), {4'h0, v, ~v});
            chk("pos hyst", {30'h0, analog_cfg[0].pos_hyst_sel}, {30'h0, v});
            chk("neg hyst", {30'h0, analog_cfg[0].neg_hyst_sel}, {30'h0, ~v});
            wt(ra(0, 1), {6'h3F, v});
            rdc("mode rb", ra(0, 1), {6'h0C, v});
            chk("speed", {30'h0, analog_cfg[0].speed_power_sel}, {30'h0, v});
        end
        rdc("ctrl rb", ra(0, 0), 8'h0C);
        wt(ra(0, 1), 8'h02);
        wt(ra(0, 0), 8'h00);
        for (int i = 0; i < 2; i++)
        begin
            ma = `VCC_BYTE_ADDR(i ? `VCC_MUX1_IDX : `VCC_MUX0_IDX);
            rdc("mux reset", ma, `VCC_MUX_RST);
            wt(ma, 8'h5A);
            chk("plus sel", {28'h0, analog_cfg[i].plus_input_sel}, 32'hA);
            chk("minus sel", {28'h0, analog_cfg[i].minus_input_sel}, 32'h5);
            @(posedge pclk);
            pstrb <= 4'hE;
            wt(ma, 8'hC3);
            @(posedge pclk);
            pstrb <= 4'hF;
            rdc("lane gate", ma, 8'h5A);
        end
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("t_fields done");
    endtask

    task automatic t_edges(input int i);
        logic [11:0] c;
        logic [11:0] m;
        c = ra(i, 0);
        m = ra(i, 1);
        lv(i, 1'b1);
        chk("raw off", {31'h0, pin_out[i].raw_cmp_out}, 32'h0);
        rdc("no edge off", c, 8'h00);
        wt(c, 8'h80);
        chk("raw on", {31'h0, pin_out[i].raw_cmp_out}, 32'h1);
        repeat (6) @(posedge pclk);
        rdc("rise set", c, 8'hE0);
        wt(c, 8'h80);
        rdc("rise clear", c, 8'hC0);
        wt(m, 8'h12);
        lv(i, 1'b0);
        rdc("fall set", c, 8'h90);
        chk("fall irq", {31'h0, cmp_irq[i]}, 32'h1);
        chk("reset src", {31'h0, reset_src_out}, (i == 0) ? 32'h1 : 32'h0);
        chk("latched", {31'h0, pin_out[i].latched_cmp_out}, 32'h0);
        lv(i, 1'b1);
        rdc("both kept", c, 8'hF0);
        wt(m, 8'h02);
        irqc(i, 1'b0);
        wt(m, 8'h22);
        irqc(i, 1'b1);
        wt(c, 8'hD0);
        irqc(i, 1'b0);
        rdc("fall kept", c, 8'hD0);
        wt(c, 8'h00);
        chk("raw disable", {31'h0, pin_out[i].raw_cmp_out}, 32'h0);
        repeat (6) @(posedge pclk);
        rdc("disable edge", c, 8'h10);
        chk("latched off", {31'h0, pin_out[i].latched_cmp_out}, 32'h0);
        wt(c, 8'h00);
        wt(m, 8'h02);
        $display("t_edges done");
    endtask

    // Main sequence: reset held eight cycles, then the scenarios
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        level = 2'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_edges(0);
        t_edges(1);
        stop_test();
    end
endmodule // tb_top

bind vcc_top vcc_sva #(.NUM_CMP(NUM_CMP)) vcc_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cmp_analog(cmp_analog), .analog_cfg(analog_cfg),
    .pin_out(pin_out), .cmp_irq(cmp_irq), .reset_src_out(reset_src_out));
